// ==== hw/standby_sense_and_hold_key.sv ====
// Standby sensing cycle, baseline accumulation, hold key timing and their registers.
`timescale 1ns/10ps
// Function
// - Standby cycle period codes 0-3 give 35, 70, 105, 140 ms; reset 70 ms.
// - A standby cycle stretches until every programmed sample has been taken.
// - Standby gain codes 0-7 give 128x down to 1x, halving; reset 32x.
// - Standby deltas are scaled by the selected gain before comparison.
// - Seven-bit standby threshold at 43h, reset 40h; delta above it is a touch.
// - Read-only baselines at 50h-52h, reset C8h, updated during calibration.
// - Readings accumulate until sample size, then upper 16 bits load baseline, adder clears.
// - The baseline shift field chooses which baseline bits the registers show.
// - Key select at 60h, reset 00h, codes 0, 1, 2 pick inputs one to three.
// - Config bit 6 enables the hold key in standby; reset disabled.
// - Config bit 2 enables the hold key in active state; reset disabled.
// - Hold duration codes give 280, 560, 1120, 2240 ms; config at 61h resets 22h.
// - Active hold of the selected input for the active duration sets flag and interrupt.
// - Standby hold of the selected input for the standby duration sets flag and interrupt.
// - Only watched inputs are sampled in standby, with standby settings.
// - Standby sample count codes give 1 to 128 samples, reset 8, taken consecutively.
`include "hold_key_defines.svh"
module standby_sense_and_hold_key
  import hold_key_pkg::*;
#(
  parameter int CLOCKS_PER_MS = `CLOCKS_PER_MS,
  parameter int DELTA_WIDTH = 16,
  parameter int ADDER_WIDTH = 24,
  parameter logic [6:0] DEVICE_ADDRESS = 7'h28
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic standby_mode,
  input wire logic [2:0] active_touch,
  output logic sample_req,
  output logic [1:0] sample_input,
  input wire logic sample_done,
  input wire logic [DELTA_WIDTH-1:0] sample_delta,
  output logic [2:0] standby_touch,
  input wire logic cal_valid,
  input wire logic [1:0] cal_input,
  input wire logic [15:0] cal_count,
  input wire logic [2:0] cal_size_log2,
  output logic hold_key_flag,
  output logic hold_key_irq
);
  localparam int SUM_WIDTH = DELTA_WIDTH + 7;
  localparam int SCALED_WIDTH = SUM_WIDTH + `GAIN_MAX_SHIFT;

  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr;
  logic [7:0] standby_watch_r, standby_config_r, standby_gain_r, standby_threshold_r;
  logic [7:0] hold_key_select_r, hold_key_config_r, baseline_shift_r;
  logic [15:0] baseline_r [3];

  function automatic logic [11:0] hold_ms(input logic [1:0] code);
    hold_ms = 12'(`HOLD_BASE_MS) << code;
  endfunction

  function automatic logic [7:0] shown_baseline(input logic [15:0] base, input logic [3:0] sh);
    shown_baseline = 8'(base >> sh);
  endfunction

  serial_register_port #(.DEVICE_ADDRESS(DEVICE_ADDRESS)) port_u (
    .clock(clock),
    .reset_n(reset_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  // Configuration registers; reserved bits are not stored and read as zero, except in standby config, which stores all eight bits.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      standby_watch_r <= `RESET_STANDBY_WATCH;
      standby_config_r <= `RESET_STANDBY_CONFIG;
      standby_gain_r <= `RESET_STANDBY_GAIN;
      standby_threshold_r <= `RESET_STANDBY_THRESHOLD;
      hold_key_select_r <= `RESET_HOLD_KEY_SELECT;
      hold_key_config_r <= `RESET_HOLD_KEY_CONFIG;
      baseline_shift_r <= `RESET_BASELINE_SHIFT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `REG_STANDBY_WATCH: standby_watch_r <= reg_wdata & 8'h07;
        `REG_STANDBY_CONFIG: standby_config_r <= reg_wdata;
        `REG_STANDBY_GAIN: standby_gain_r <= reg_wdata & 8'h07;
        `REG_STANDBY_THRESHOLD: standby_threshold_r <= reg_wdata & 8'h7F;
        `REG_HOLD_KEY_SELECT: hold_key_select_r <= reg_wdata & 8'h07;
        `REG_HOLD_KEY_CONFIG: hold_key_config_r <= reg_wdata & 8'h77;
        `REG_BASELINE_SHIFT: baseline_shift_r <= reg_wdata & 8'h0F;
        // Baseline registers take no write path at all.
        default: baseline_shift_r <= baseline_shift_r;
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr)
      `REG_GENERAL_STATUS: reg_rdata = 8'(hold_key_flag) << `STATUS_HOLD_KEY_BIT;
      `REG_BASELINE_SHIFT: reg_rdata = baseline_shift_r;
      `REG_STANDBY_WATCH: reg_rdata = standby_watch_r;
      `REG_STANDBY_CONFIG: reg_rdata = standby_config_r;
      `REG_STANDBY_GAIN: reg_rdata = standby_gain_r;
      `REG_STANDBY_THRESHOLD: reg_rdata = standby_threshold_r;
      // The shift applies at read time, so a new shift shows at once on the stored baseline.
      `REG_INPUT_ONE_BASELINE:
        reg_rdata = shown_baseline(baseline_r[0], baseline_shift_r[3:0]);
      `REG_INPUT_TWO_BASELINE:
        reg_rdata = shown_baseline(baseline_r[1], baseline_shift_r[3:0]);
      `REG_INPUT_THREE_BASELINE:
        reg_rdata = shown_baseline(baseline_r[2], baseline_shift_r[3:0]);
      `REG_HOLD_KEY_SELECT: reg_rdata = hold_key_select_r;
      `REG_HOLD_KEY_CONFIG: reg_rdata = hold_key_config_r;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Millisecond timebase shared by the standby cycle and the hold timer.
  logic [31:0] prescale_r;
  logic ms_tick_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescale_r <= 32'h0;
      ms_tick_r <= 1'b0;
    end else if (prescale_r == 32'(CLOCKS_PER_MS - 1)) begin
      prescale_r <= 32'h0;
      ms_tick_r <= 1'b1;
    end else begin
      prescale_r <= prescale_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  // Standby sensing sequencer.
  standby_state_type sb_state_r;
  logic [7:0] elapsed_ms_r;
  logic [7:0] period_ms;
  logic [1:0] chan_r;
  logic [7:0] taken_r;
  logic [7:0] needed;
  logic [SUM_WIDTH-1:0] sum_r;
  logic [SUM_WIDTH-1:0] measured;
  logic [SCALED_WIDTH-1:0] scaled;
  logic [2:0] touch_r;

  assign period_ms = 8'(`CYCLE_STEP_MS) * (8'(standby_config_r[`CONFIG_PERIOD_LSB +: 2]) + 8'h01);
  assign needed = 8'h01 << standby_config_r[`CONFIG_COUNT_LSB +: 3];
  assign measured = standby_config_r[`CONFIG_SUM_BIT] ? sum_r :
    (sum_r >> standby_config_r[`CONFIG_COUNT_LSB +: 3]);
  assign scaled = SCALED_WIDTH'(measured) <<
    (3'(`GAIN_MAX_SHIFT) - standby_gain_r[2:0]);
  assign sample_req = (sb_state_r == SB_REQUEST);
  assign sample_input = chan_r;
  assign standby_touch = touch_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      elapsed_ms_r <= 8'hFF;
    end else if (!standby_mode) begin
      // Saturated so that the first cycle starts as soon as standby begins.
      elapsed_ms_r <= 8'hFF;
    end else if ((sb_state_r == SB_IDLE) && (elapsed_ms_r >= period_ms)) begin
      elapsed_ms_r <= 8'h00;
    end else if (ms_tick_r && (elapsed_ms_r != 8'hFF)) begin
      elapsed_ms_r <= elapsed_ms_r + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sb_state_r <= SB_IDLE;
      chan_r <= 2'h0;
      taken_r <= 8'h00;
      sum_r <= '0;
      touch_r <= 3'h0;
    end else if (!standby_mode) begin
      sb_state_r <= SB_IDLE;
      chan_r <= 2'h0;
      touch_r <= 3'h0;
    end else begin
      unique case (sb_state_r)
        SB_IDLE: if (elapsed_ms_r >= period_ms) begin
          // A late finish already leaves the period spent, so the cycle just stretches.
          chan_r <= 2'h0;
          sb_state_r <= SB_SCAN;
        end
        SB_SCAN: if (chan_r == 2'h3) begin
          sb_state_r <= SB_IDLE;
        end else if (standby_watch_r[chan_r]) begin
          taken_r <= 8'h00;
          sum_r <= '0;
          sb_state_r <= SB_REQUEST;
        end else begin
          touch_r[chan_r] <= 1'b0;
          chan_r <= chan_r + 2'h1;
        end
        SB_REQUEST: sb_state_r <= SB_WAIT;
        SB_WAIT: if (sample_done) begin
          sum_r <= sum_r + SUM_WIDTH'(sample_delta);
          taken_r <= taken_r + 8'h01;
          // All samples of one input follow each other before the next input.
          // At or above, so lowering the count in mid-cycle cannot run the counter round.
          sb_state_r <= (taken_r + 8'h01 >= needed) ? SB_EVAL : SB_REQUEST;
        end
        SB_EVAL: begin
          touch_r[chan_r] <= scaled > SCALED_WIDTH'(standby_threshold_r[6:0]);
          chan_r <= chan_r + 2'h1;
          sb_state_r <= SB_SCAN;
        end
      endcase
    end
  end

  // Baseline adders, one per input.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_baseline
      logic [ADDER_WIDTH-1:0] adder_r, adder_nxt;
      logic [7:0] count_r;
      logic hit;

      assign hit = cal_valid && (cal_input == 2'(gi));
      assign adder_nxt = adder_r + ADDER_WIDTH'(cal_count);

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          adder_r <= '0;
          count_r <= 8'h00;
          baseline_r[gi] <= 16'(`RESET_BASELINE);
        end else if (hit && (count_r + 8'h01 == (8'h01 << cal_size_log2))) begin
          baseline_r[gi] <= adder_nxt[ADDER_WIDTH-1 -: 16];
          adder_r <= '0;
          count_r <= 8'h00;
        end else if (hit) begin
          adder_r <= adder_nxt;
          count_r <= count_r + 8'h01;
        end
      end
    end
  endgenerate

  // Hold key timer.
  logic selected_touch, hold_enable, fired_r;
  logic [1:0] duration_code;
  logic [11:0] held_ms_r;

  always_comb begin
    selected_touch = 1'b0;
    if (hold_key_select_r[2:0] < 3'h3) begin
      selected_touch = standby_mode ? touch_r[hold_key_select_r[1:0]] :
        active_touch[hold_key_select_r[1:0]];
    end
    hold_enable = standby_mode ? hold_key_config_r[`HOLD_STANDBY_ENABLE_BIT] :
      hold_key_config_r[`HOLD_ACTIVE_ENABLE_BIT];
    duration_code = standby_mode ? hold_key_config_r[`HOLD_STANDBY_TIME_LSB +: 2] :
      hold_key_config_r[`HOLD_ACTIVE_TIME_LSB +: 2];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      held_ms_r <= 12'h000;
      fired_r <= 1'b0;
      hold_key_irq <= 1'b0;
    end else begin
      hold_key_irq <= 1'b0;
      if (!selected_touch || !hold_enable) begin
        held_ms_r <= 12'h000;
        fired_r <= 1'b0;
      end else if (!fired_r && (held_ms_r >= hold_ms(duration_code))) begin
        fired_r <= 1'b1;
        hold_key_irq <= 1'b1;
      end else if (ms_tick_r && !fired_r) begin
        held_ms_r <= held_ms_r + 12'h001;
      end
    end
  end

  // A status write with the flag bit at zero clears it, but a new hold wins.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_key_flag <= 1'b0;
    end else if (hold_key_irq) begin
      hold_key_flag <= 1'b1;
    end else if (reg_wr && (reg_addr == `REG_GENERAL_STATUS) &&
        !reg_wdata[`STATUS_HOLD_KEY_BIT]) begin
      hold_key_flag <= 1'b0;
    end
  end
endmodule // standby_sense_and_hold_key

// ==== inc/hold_key_defines.svh ====
// Register offsets, field positions, reset values and timing figures of the sensing block.
`ifndef HOLD_KEY_DEFINES_SVH
`define HOLD_KEY_DEFINES_SVH

`define CLOCK_HZ 25000000
`define MS_PER_SECOND 1000
`define CLOCKS_PER_MS (`CLOCK_HZ / `MS_PER_SECOND)

`define REG_GENERAL_STATUS 8'h02
`define REG_BASELINE_SHIFT 8'h2F
`define REG_STANDBY_WATCH 8'h40
`define REG_STANDBY_CONFIG 8'h41
`define REG_STANDBY_GAIN 8'h42
`define REG_STANDBY_THRESHOLD 8'h43
`define REG_INPUT_ONE_BASELINE 8'h50
`define REG_INPUT_TWO_BASELINE 8'h51
`define REG_INPUT_THREE_BASELINE 8'h52
`define REG_HOLD_KEY_SELECT 8'h60
`define REG_HOLD_KEY_CONFIG 8'h61

`define RESET_BASELINE_SHIFT 8'h00
`define RESET_STANDBY_WATCH 8'h00
`define RESET_STANDBY_CONFIG 8'h39
`define RESET_STANDBY_GAIN 8'h02
`define RESET_STANDBY_THRESHOLD 8'h40
`define RESET_BASELINE 8'hC8
`define RESET_HOLD_KEY_SELECT 8'h00
`define RESET_HOLD_KEY_CONFIG 8'h22

`define STATUS_HOLD_KEY_BIT 4
`define CONFIG_SUM_BIT 7
`define CONFIG_COUNT_LSB 4
`define CONFIG_PERIOD_LSB 0
`define HOLD_STANDBY_ENABLE_BIT 6
`define HOLD_STANDBY_TIME_LSB 4
`define HOLD_ACTIVE_ENABLE_BIT 2
`define HOLD_ACTIVE_TIME_LSB 0

`define CYCLE_STEP_MS 35
`define HOLD_BASE_MS 280
`define GAIN_MAX_SHIFT 7

`endif

// ==== inc/hold_key_pkg.sv ====
// Types shared by the sensing block and its serial register port.
package hold_key_pkg;

  typedef enum logic [8:0] {
    SER_IDLE = 9'h001,
    SER_ADDR = 9'h002,
    SER_ACK_ADDR = 9'h004,
    SER_POINTER = 9'h008,
    SER_ACK_POINTER = 9'h010,
    SER_WRITE = 9'h020,
    SER_ACK_WRITE = 9'h040,
    SER_READ = 9'h080,
    SER_ACK_READ = 9'h100
  } serial_state_type;

  typedef enum logic [4:0] {
    SB_IDLE = 5'h01,
    SB_SCAN = 5'h02,
    SB_REQUEST = 5'h04,
    SB_WAIT = 5'h08,
    SB_EVAL = 5'h10
  } standby_state_type;

endpackage

// ==== hw/serial_register_port.sv ====
// Two-wire serial slave that turns bus transfers into register reads and writes.
`timescale 1ns/10ps
module serial_register_port
  import hold_key_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h28
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rdata
);
  serial_state_type state_r;
  logic scl_r, sda_r, rw_r, master_ack_r;
  logic [3:0] count_r;
  logic [7:0] shift_r, tx_r;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  assign scl_rise = scl & ~scl_r;
  assign scl_fall = ~scl & scl_r;
  assign start_seen = scl & scl_r & sda_r & ~sda_in;
  assign stop_seen = scl & scl_r & ~sda_r & sda_in;
  assign sda_out = 1'b0;
  assign sda_oe = (state_r == SER_ACK_ADDR) || (state_r == SER_ACK_POINTER) ||
    (state_r == SER_ACK_WRITE) || ((state_r == SER_READ) && !tx_r[7]);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda_in;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SER_IDLE;
      count_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'hFF;
      rw_r <= 1'b0;
      master_ack_r <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      if (start_seen) begin
        state_r <= SER_ADDR;
        count_r <= 4'h0;
        tx_r <= 8'hFF;
      end else if (stop_seen) begin
        state_r <= SER_IDLE;
        tx_r <= 8'hFF;
      end else if (scl_rise) begin
        shift_r <= {shift_r[6:0], sda_in};
        count_r <= count_r + 4'h1;
        master_ack_r <= ~sda_in;
      end else if (scl_fall) begin
        unique case (state_r)
          SER_IDLE: state_r <= SER_IDLE;
          SER_ADDR: if (count_r == 4'h8) begin
            rw_r <= shift_r[0];
            state_r <= (shift_r[7:1] == DEVICE_ADDRESS) ? SER_ACK_ADDR : SER_IDLE;
          end
          SER_ACK_ADDR: begin
            count_r <= 4'h0;
            if (rw_r) begin
              tx_r <= reg_rdata;
              state_r <= SER_READ;
            end else begin
              state_r <= SER_POINTER;
            end
          end
          SER_POINTER: if (count_r == 4'h8) begin
            reg_addr <= shift_r;
            state_r <= SER_ACK_POINTER;
          end
          SER_ACK_POINTER: begin
            count_r <= 4'h0;
            state_r <= SER_WRITE;
          end
          SER_WRITE: if (count_r == 4'h8) begin
            reg_wdata <= shift_r;
            reg_wr <= 1'b1;
            state_r <= SER_ACK_WRITE;
          end
          SER_ACK_WRITE: begin
            count_r <= 4'h0;
            reg_addr <= reg_addr + 8'h01;
            state_r <= SER_WRITE;
          end
          SER_READ: if (count_r == 4'h8) begin
            tx_r <= 8'hFF;
            state_r <= SER_ACK_READ;
          end else begin
            tx_r <= {tx_r[6:0], 1'b1};
          end
          SER_ACK_READ: begin
            count_r <= 4'h0;
            if (master_ack_r) begin
              reg_addr <= reg_addr + 8'h01;
              tx_r <= reg_rdata;
              state_r <= SER_READ;
            end else begin
              state_r <= SER_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule // serial_register_port

// ==== tb/standby_sense_and_hold_key_assertions.sv ====
// Port-level assertions for the standby sensing and hold key block.
`timescale 1ns/10ps
module standby_sense_and_hold_key_assertions #(
  parameter int CLOCKS_PER_MS = 25000
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic standby_mode,
  input wire logic [2:0] active_touch,
  input wire logic sample_req,
  input wire logic [1:0] sample_input,
  input wire logic sample_done,
  input wire logic [2:0] standby_touch,
  input wire logic hold_key_flag,
  input wire logic hold_key_irq
);
  // Shortest hold less one tick, because the millisecond timebase runs free.
  localparam int MIN_HOLD = 279 * CLOCKS_PER_MS;
  logic waiting_r;
  logic any_touch;
  logic [31:0] held_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  assign any_touch = standby_mode ? |standby_touch : |active_touch;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) waiting_r <= 1'b0;
    else if (!standby_mode || sample_done) waiting_r <= 1'b0;
    else if (sample_req) waiting_r <= 1'b1;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) held_r <= 32'h0;
    else if (!any_touch) held_r <= 32'h0;
    else held_r <= held_r + 32'h1;
  sequence leave_standby;
    $fell(standby_mode);
  endsequence
  sequence one_cycle_req;
    sample_req ##1 !sample_req;
  endsequence
  a_req_one_cycle: assert property (sample_req |-> one_cycle_req)
    else $error("sample request longer than one cycle");
  a_req_not_outstanding: assert property (sample_req |-> !waiting_r)
    else $error("new sample request while one is outstanding");
  a_input_held_stable: assert property (waiting_r && standby_mode |-> $stable(sample_input))
    else $error("sample input changed while waiting");
  a_irq_one_cycle: assert property (hold_key_irq |=> !hold_key_irq)
    else $error("hold key interrupt longer than one cycle");
  a_irq_sets_flag: assert property (hold_key_irq |-> ##[0:1] hold_key_flag)
    else $error("hold key flag not set with interrupt");
  a_hold_min_time: assert property (hold_key_irq |-> held_r >= MIN_HOLD)
    else $error("hold key interrupt before shortest hold time");
  a_leave_clears_touch: assert property (leave_standby |-> ##[1:2] standby_touch == 3'h0)
    else $error("standby touches not cleared on leaving standby");
  a_no_req_active: assert property (!standby_mode [*2] |-> !sample_req)
    else $error("sample request outside standby");
endmodule // standby_sense_and_hold_key_assertions

bind standby_sense_and_hold_key standby_sense_and_hold_key_assertions #(
  .CLOCKS_PER_MS(CLOCKS_PER_MS)
) i_assertions (
  .clock, .reset_n, .standby_mode, .active_touch, .sample_req, .sample_input, .sample_done,
  .standby_touch, .hold_key_flag, .hold_key_irq
);

// ==== tb/serial_host_model.sv ====
// Host side of the two-wire register port, acting as bus master.
`timescale 1ns/10ps
module serial_host_model #(
  parameter logic [6:0] ADDR = 7'h28
) (
  input wire logic clock,
  output logic scl,
  output logic host_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  // Data moves only while the clock line is low, so no false start or stop is seen.
  task automatic bit_xfer(logic b, output logic got);
    host_low <= !b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    got = sda;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask
  // Start when s is high, stop when low.
  task automatic framing(logic s);
    host_low <= !s;
    tick(2);
    scl <= 1'b1;
    tick(4);
    host_low <= s;
    tick(4);
    scl <= !s;
    tick(2);
  endtask
  // A byte of all ones leaves the line released, so one transfer serves reading too.
  task automatic byte_xfer(logic [7:0] b, logic last, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], got[i]);
    bit_xfer(last, ack);
  endtask
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    logic [7:0] g;
    logic k;
    framing(1'b1);
    byte_xfer({ADDR, 1'b0}, 1'b1, g, k);
    byte_xfer(a, 1'b1, g, k);
    byte_xfer(d, 1'b1, g, k);
    framing(1'b0);
  endtask
  task automatic reg_read(logic [7:0] a, output logic [7:0] d);
    logic k;
    framing(1'b1);
    byte_xfer({ADDR, 1'b0}, 1'b1, d, k);
    byte_xfer(a, 1'b1, d, k);
    framing(1'b1);
    byte_xfer({ADDR, 1'b1}, 1'b1, d, k);
    byte_xfer(8'hFF, 1'b1, d, k);
    framing(1'b0);
  endtask
endmodule // serial_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the standby sensing and hold key block.
`timescale 1ns/10ps
module tb;
  localparam int CPM = 10;
  logic clock, reset_n, scl, sda, host_low, sda_out, sda_oe, standby_mode, sample_req, k;
  logic sample_done, cal_valid, hold_key_flag, hold_key_irq;
  logic [2:0] active_touch, standby_touch, cal_size_log2;
  logic [1:0] sample_input, cal_input, last_in;
  logic [15:0] sample_delta, cal_count, a, b;
  logic [7:0] rd, t;
  int n_fail, compares, cyc, n_req, n_irq, req_cyc, period, last_done, max_gap, fe_wait;
  int fe_delay, sel, s;
  logic [7:0] addr_tab [8] = '{8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h60, 8'h61};
  logic [7:0] reset_tab [8] = '{8'h39, 8'h02, 8'h40, 8'hC8, 8'hC8, 8'hC8, 8'h00, 8'h22};
  assign sda = (sda_oe ? sda_out : 1'b1) & !host_low;
  standby_sense_and_hold_key #(.CLOCKS_PER_MS(CPM)) i_standby_sense_and_hold_key (.clock,
    .reset_n, .scl, .sda_in(sda), .sda_out, .sda_oe, .standby_mode, .active_touch, .sample_req,
    .sample_input, .sample_done, .sample_delta, .standby_touch, .cal_valid, .cal_input,
    .cal_count, .cal_size_log2, .hold_key_flag, .hold_key_irq);
  serial_host_model host (.clock, .scl, .host_low, .sda);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Front end answers each request after fe_delay clocks and logs request timing.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    sample_done <= 1'b0;
    if (hold_key_irq) n_irq <= n_irq + 1;
    if (sample_req) begin
      n_req <= n_req + 1;
      period <= cyc - req_cyc;
      req_cyc <= cyc;
      if (cyc - last_done > max_gap) max_gap <= cyc - last_done;
      fe_wait <= fe_delay;
      last_in <= sample_input;
    end else if (fe_wait > 0) begin
      fe_wait <= fe_wait - 1;
      sample_done <= fe_wait == 1;
      last_done <= cyc;
    end
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rdchk(logic [7:0] ad, logic [7:0] exp);
    host.reg_read(ad, rd);
    check($sformatf("register %h", ad), exp, rd);
  endtask
  task automatic cal_read(logic [1:0] i, logic [15:0] x);
    cal_valid <= 1'b1;
    cal_input <= i;
    cal_count <= x;
    @(posedge clock);
    cal_valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_reqs(int n);
    int n0 = n_req;
    for (int c = 0; n_req < n0 + n; c++) begin
      @(posedge clock);
      if (c > 20000) check("request timeout", 0, 1);
      if (c > 20000) test_done();
    end
  endtask
  task automatic wait_irq(int lo, int hi);
    int c = 0;
    for (; hold_key_irq !== 1'b1 && c <= hi; c++) @(posedge clock);
    check("hold time", 1, c >= lo && c <= hi);
    if (c > hi) test_done();
  endtask
  function automatic logic [7:0] exp_base(logic [15:0] x, logic [15:0] y, logic [3:0] sh);
    logic [23:0] sum;
    sum = 24'(x) + 24'(y);
    return 8'(sum[23:8] >> sh);
  endfunction
  initial begin
    reset_n = 1'b0;
    standby_mode = 1'b0;
    active_touch = 3'h0;
    sample_delta = 16'h0000;
    cal_valid = 1'b0;
    cal_input = 2'h0;
    cal_count = 16'h0000;
    cal_size_log2 = 3'h1;
    fe_delay = 1;
    s = $urandom(60417);
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    foreach (addr_tab[i]) rdchk(addr_tab[i], reset_tab[i]);
    for (int i = 0; i < 2; i++) begin
      host.framing(1'b1);
      host.byte_xfer({7'h28 + 7'(i), 1'b0}, 1'b1, rd, k);
      host.framing(1'b0);
      check("address ack", 16'(i), 16'(k));
    end
    host.reg_write(8'h50, 8'($urandom));
    rdchk(8'h50, 8'hC8);
    rdchk(8'h70, 8'h00);
    t = 8'($urandom_range(127, 0));
    host.reg_write(8'h43, t);
    rdchk(8'h43, t);
    // The second pass on each input shows that the adder restarted from zero.
    for (int i = 0; i < 6; i++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      t = 8'($urandom_range(3, 0));
      cal_size_log2 <= 3'($urandom_range(1, 0));
      host.reg_write(8'h2F, t);
      cal_read(2'(i % 3), a);
      cal_read(2'(i % 3), b);
      // With a sample size of one, the second reading alone makes the baseline.
      if (cal_size_log2 == 3'h0) a = 16'h0000;
      rdchk(8'h50 + 8'(i % 3), exp_base(a, b, t[3:0]));
    end
    sel = $urandom_range(2, 0);
    host.reg_write(8'h60, 8'(sel));
    for (int j = 0; j < 2; j++) begin
      host.reg_write(8'h61, j ? 8'h04 : 8'h00);
      active_touch <= j ? ~(3'h1 << sel) : 3'h1 << sel;
      s = n_irq;
      repeat (3200) @(posedge clock);
      active_touch <= 3'h0;
      check("irq count", 16'(s), 16'(n_irq));
    end
    active_touch <= 3'h1 << sel;
    repeat (2000) @(posedge clock);
    active_touch <= 3'h0;
    @(posedge clock);
    active_touch <= 3'h1 << sel;
    wait_irq(2785, 2815);
    active_touch <= 3'h0;
    host.reg_read(8'h02, rd);
    check("flag bit", 1, rd[4]);
    host.reg_write(8'h02, 8'h00);
    check("flag cleared", 0, hold_key_flag);
    host.reg_write(8'h40, 8'h01 << sel);
    host.reg_write(8'h61, 8'h50);
    standby_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      host.reg_write(8'h41, 8'(c));
      wait_reqs(3);
      check("cycle period", 1, period >= 350 * (c + 1) - 12 && period <= 350 * (c + 1) + 12);
      check("sampled input", 16'(sel), 16'(last_in));
    end
    fe_delay = 3;
    host.reg_write(8'h41, 8'h70);
    wait_reqs(130);
    max_gap = 0;
    wait_reqs(300);
    check("overrun gap", 1, max_gap < 10);
    fe_delay = 1;
    // At most four samples, averaged or summed, so every cycle still fits in 35 ms.
    for (int g = 0; g < 8; g++) begin
      a = 16'($urandom_range(3, 0));
      b = {12'h000, 1'($urandom), 3'($urandom_range(2, 0))};
      t = 8'($urandom_range(127, 0));
      sample_delta <= a;
      host.reg_write(8'h41, {b[3:0], 4'h0});
      host.reg_write(8'h42, 8'(g));
      host.reg_write(8'h43, t);
      repeat (800) @(posedge clock);
      check("standby touch",
        3'(((32'(a) << (b[3] ? b[2:0] : 3'h0)) << (7 - g)) > 32'(t)) << sel,
        standby_touch);
    end
    sample_delta <= 16'h0000;
    repeat (800) @(posedge clock);
    host.reg_write(8'h42, 8'h00);
    sample_delta <= 16'h0001;
    for (s = 0; standby_touch[sel] !== 1'b1 && s < 1000; s++) @(posedge clock);
    wait_irq(5585, 5615);
    standby_mode <= 1'b0;
    repeat (3) @(posedge clock);
    check("touch after standby", 0, standby_touch);
    test_done();
  end
endmodule // tb
